// ### rtl/ch_decoder.sv
/*
 Instruction decoder and sequencer of a character display controller:
 host strobes and two-wire byte stream in, mode bits and RAM accesses out.
 Assumes host strobes synchronous to CLK, one cycle wide.
*/
`timescale 1ns/1ps
`include "ch_defines.svh"

// Function
// (R1) At power-up run screen clear, busy 165 cycles, then idle.
// (R2) Reset: increment, no shift, 8-bit, 1-line, basic set, icons and config zero.
// (R3) Reset: display, cursor and cursor blink all off.
// (R4) Host writes only instruction and data holding registers, latched before execution.
// (R5) While busy, only the busy/pointer read is served.
// (R6) Busy is 1 during execution; commands arriving while busy are dropped.
// (R7) Host polls busy or waits the longest execution time.
// (R8) Two-wire control byte: continuation bit, select bit, six zeros, then byte.
// (R9) Two-wire read/write comes from the slave address direction.
// (R10) Code 0x00 idles 3 cycles; function set loads width, lines, set select.
// (R11) Select 0 read returns busy in bit 7, pointer below, no cost; in the last cycle of a data read the RAM byte is returned instead.
// (R12) Select 1 reads or writes the addressed RAM byte in 3 cycles.
// (R13) Basic 0x01 blanks the screen, pointer to display address 0, 165 cycles.
// (R14) Basic 0x02 homes pointer and shift, RAM kept, 3 cycles.
// (R15) Entry mode loads step direction and shift enable for data accesses.
// (R16) Display control loads display, cursor, blink; display off powers down.
// (R17) Cursor/display shift by bit 3, direction bit 2, RAM unchanged.
// (R18) Glyph address loads six bits keeping bit 6; display address loads seven.
// (R19) Extended set loads mirroring, column/row order, icon mode and blink.
// (R20) Host never issues reserved extended codes.
// (R21) Each data write steps the pointer by one up or down.
// (R22) With shift enabled the display shifts within the data write.
// (R23) Clear writes 0x20 everywhere, forces increment, keeps shift enable; the walk writes display bytes 0x00 to 0x4F only.
// (R24) Return home keeps step direction and shift enable.
// (R25) Continuation 1: control byte follows; 0: only data bytes follow.
// (R26) Reserved codes change no mode, pointer or RAM.
module ch_decoder
    import ch_pkg::*;
(
    input  wire logic          CLK,
    input  wire logic          RST_N,
    input  wire ch_host_req_t  HOST_REQ,
    input  wire ch_i2c_in_t    I2C_IN,
    output logic               BUSY,
    output logic               RD_VALID,
    output logic [7:0]         RD_DATA,
    output ch_mode_t           MODE,
    output logic [6:0]         RAM_POINTER,
    output logic [6:0]         DISP_SHIFT,
    output logic               PWR_DOWN
);

    // ==========================================================
    // State
    ch_state_t  state_ff,      nxt_state;
    logic [7:0] cnt_ff,        nxt_cnt;
    logic [6:0] ptr_ff,        nxt_ptr;
    logic       gsel_ff,       nxt_gsel;
    logic [6:0] shift_ff,      nxt_shift;
    logic [6:0] clr_ff,        nxt_clr;
    ch_mode_t   mode_ff,       nxt_mode;
    logic       busy_ff;
    logic       rdv_ff,        nxt_rdv;
    logic [7:0] rd_data_ff,    nxt_rdata;
    logic       pwr_ff;
    logic [7:0] ihr_ff;
    logic [7:0] dhr_ff;
    logic       data_ff;
    logic       expect_ctrl_ff;
    logic       i2c_rs_ff;
    logic       i2c_co_ff;
    logic [7:0] mem_rdata;

    function automatic logic top_is(input logic [7:0] v, input int k);
        return (v >> k) == 8'h01;
    endfunction

    // ==========================================================
    // Two-wire byte parsing
    // (R8) control byte check
    wire i2c_ctrl_ok = I2C_IN.data[5:0] == `CH_CTRL_ZERO;
    wire i2c_is_ctrl = I2C_IN.byte_vld & expect_ctrl_ff;
    wire i2c_wr      = I2C_IN.byte_vld & ~expect_ctrl_ff;

    // (R25) continuation handling
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            expect_ctrl_ff <= 1'b1;
            i2c_rs_ff      <= 1'b0;
            i2c_co_ff      <= 1'b0;
        end else if (I2C_IN.start) begin
            expect_ctrl_ff <= 1'b1;
        end else if (i2c_is_ctrl && i2c_ctrl_ok) begin
            expect_ctrl_ff <= 1'b0;
            i2c_rs_ff      <= I2C_IN.data[`CH_B_RS];
            i2c_co_ff      <= I2C_IN.data[`CH_B_CO];
        end else if (i2c_wr) begin
            expect_ctrl_ff <= i2c_co_ff;
        end
    end

    // ==========================================================
    // Request merge; parallel strobes win a same-cycle clash
    wire       par_act  = HOST_REQ.wr | HOST_REQ.rd;
    wire       req_wr   = par_act ? HOST_REQ.wr : i2c_wr;
    // (R9) direction from which strobe arrives, not the control byte
    wire       req_rd   = par_act ? HOST_REQ.rd : I2C_IN.rd_req;
    wire       req_rs   = par_act ? HOST_REQ.register_select : i2c_rs_ff;
    wire [7:0] req_data = par_act ? HOST_REQ.data : I2C_IN.data;

    // (R5) only the status read passes while busy
    wire idle     = state_ff == ST_IDLE;
    wire bf_read  = req_rd & ~req_rs;
    wire acc_cmd  = idle & req_wr & ~req_rs;
    wire acc_dwr  = idle & req_wr & req_rs;
    wire acc_drd  = idle & req_rd & req_rs & ~req_wr;

    // ==========================================================
    // Decode from the instruction holding register
    wire [7:0] c        = ihr_ff;
    wire       st_exec  = state_ff == ST_EXEC;
    wire       st_read  = state_ff == ST_READ;
    wire       st_clear = state_ff == ST_CLEAR;
    wire       first    = st_exec & (cnt_ff == `CH_CYC_CMD);
    wire       last     = cnt_ff == `CH_CYC_ONE;
    wire       do_cmd   = first & ~data_ff;
    wire       do_dwr   = first & data_ff;
    wire       ext      = mode_ff.ext_set;
    wire       do_clear = do_cmd & ~ext & top_is(c, `CH_OP_CLEAR);
    wire       clr_wr   = st_clear & (clr_ff < `CH_DISPLAY_RAM_SIZE);

    // Pointer and shift steps
    wire [6:0] ptr_up    = ptr_ff + `CH_PTR_ONE;
    wire [6:0] ptr_dn    = ptr_ff - `CH_PTR_ONE;
    wire [6:0] step_ptr  = mode_ff.incr ? ptr_up : ptr_dn;
    wire [6:0] shift_up  = shift_ff + `CH_PTR_ONE;
    wire [6:0] shift_dn  = shift_ff - `CH_PTR_ONE;
    wire [6:0] step_shft = mode_ff.incr ? shift_up : shift_dn;

    // ==========================================================
    // RAM port; clear walk owns the port while it runs
    wire       mem_we    = clr_wr | do_dwr;
    wire [7:0] mem_addr  = st_clear ? {`CH_SEL_DISPLAY_RAM, clr_ff} : {gsel_ff, ptr_ff};
    wire [7:0] mem_wdata = st_clear ? `CH_BLANK_CHAR : dhr_ff;

    ch_ram u_ram (
        .clk      (CLK),
        .we       (mem_we),
        .re       (acc_drd),
        .addr     (mem_addr),
        .wdata    (mem_wdata),
        .rdata_ff (mem_rdata)
    );

    // ==========================================================
    // Next-state logic
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_ptr   = ptr_ff;
        nxt_gsel  = gsel_ff;
        nxt_shift = shift_ff;
        nxt_clr   = clr_ff;
        nxt_mode  = mode_ff;
        nxt_rdv   = 1'b0;
        nxt_rdata = rd_data_ff;
        // (R11) status read, no execution cost
        if (bf_read) begin
            nxt_rdata = {busy_ff, ptr_ff};
            nxt_rdv   = 1'b1;
        end
        case (state_ff)
            ST_IDLE: begin
                // (R6) accepted work raises busy
                if (acc_cmd || acc_dwr) begin
                    nxt_state = ST_EXEC;
                    nxt_cnt   = `CH_CYC_CMD;
                end else if (acc_drd) begin
                    // (R12) read steps the pointer like a write
                    nxt_state = ST_READ;
                    nxt_cnt   = `CH_CYC_CMD;
                    nxt_ptr   = step_ptr;
                    if (mode_ff.shift_en) begin
                        nxt_shift = step_shft;
                    end
                end
            end
            ST_EXEC: begin
                nxt_cnt = cnt_ff - `CH_CYC_ONE;
                if (last) begin
                    nxt_state = ST_IDLE;
                end
                if (do_dwr) begin
                    // (R21) step after write
                    nxt_ptr = step_ptr;
                    // (R22) shift with write
                    if (mode_ff.shift_en) begin
                        nxt_shift = step_shft;
                    end
                end else if (do_cmd) begin
                    // (R10) function set in both sets; 0x00 falls through
                    if (top_is(c, `CH_OP_FUNC)) begin
                        nxt_mode.bus_width_sel = c[`CH_B_DL];
                        nxt_mode.two_line      = c[`CH_B_M];
                        nxt_mode.ext_set       = c[`CH_B_H];
                    end else if (!ext) begin
                        if (do_clear) begin
                            // (R13) clear walk, pointer home
                            nxt_state = ST_CLEAR;
                            nxt_cnt   = `CH_CYC_CLEAR - `CH_CYC_ONE;
                            nxt_clr   = `CH_PTR_ZERO;
                            nxt_ptr   = `CH_PTR_ZERO;
                            nxt_gsel  = `CH_SEL_DISPLAY_RAM;
                            nxt_shift = `CH_PTR_ZERO;
                            // (R23) increment forced, shift enable kept
                            nxt_mode.incr = 1'b1;
                        end else if (top_is(c, `CH_OP_HOME)) begin
                            // (R14) home pointer and shift
                            // (R24) entry bits untouched
                            nxt_ptr   = `CH_PTR_ZERO;
                            nxt_gsel  = `CH_SEL_DISPLAY_RAM;
                            nxt_shift = `CH_PTR_ZERO;
                        end else if (top_is(c, `CH_OP_ENTRY)) begin
                            // (R15) entry mode
                            nxt_mode.incr     = c[`CH_B_ID];
                            nxt_mode.shift_en = c[`CH_B_S];
                        end else if (top_is(c, `CH_OP_DISP)) begin
                            // (R16) display control
                            nxt_mode.disp_on   = c[`CH_B_D];
                            nxt_mode.cursor_on = c[`CH_B_C];
                            nxt_mode.blink_on  = c[`CH_B_B];
                        end else if (top_is(c, `CH_OP_SHIFT)) begin
                            // (R17) cursor move or display shift
                            if (c[`CH_B_SC]) begin
                                nxt_shift = c[`CH_B_RL] ? shift_dn : shift_up;
                            end else begin
                                nxt_ptr = c[`CH_B_RL] ? ptr_up : ptr_dn;
                            end
                        end else if (top_is(c, `CH_OP_CG)) begin
                            // (R18) six bits, pointer bit 6 kept
                            nxt_ptr  = {ptr_ff[`CH_PTR_MSB], c[`CH_CG_MSB:0]};
                            nxt_gsel = `CH_SEL_GLYPH_RAM;
                        end else if (top_is(c, `CH_OP_DD)) begin
                            // (R18) full display address
                            nxt_ptr  = c[`CH_PTR_MSB:0];
                            nxt_gsel = `CH_SEL_DISPLAY_RAM;
                        end
                    end else begin
                        // (R19) extended set
                        // (R26) 0x01 and codes from 0x10 up change nothing
                        if (top_is(c, `CH_OP_HOME)) begin
                            nxt_mode.mirror = c[`CH_B_L];
                        end else if (top_is(c, `CH_OP_ENTRY)) begin
                            nxt_mode.col_rev = c[`CH_B_P];
                            nxt_mode.row_rev = c[`CH_B_Q];
                        end else if (top_is(c, `CH_OP_DISP) && !c[`CH_B_B]) begin
                            nxt_mode.icon_mode  = c[`CH_B_IM];
                            nxt_mode.icon_blink = c[`CH_B_IB];
                        end
                    end
                end
            end
            ST_READ: begin
                nxt_cnt = cnt_ff - `CH_CYC_ONE;
                if (last) begin
                    // Data answer wins over a status read in the same cycle
                    nxt_state = ST_IDLE;
                    nxt_rdata = mem_rdata;
                    nxt_rdv   = 1'b1;
                end
            end
            ST_CLEAR: begin
                nxt_cnt = cnt_ff - `CH_CYC_ONE;
                if (clr_wr) begin
                    nxt_clr = clr_ff + `CH_PTR_ONE;
                end
                if (last) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Sequencer registers
    // (R1) reset lands in the clear walk with its full cost
    // (R2) (R3) reset mode value
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff   <= ST_CLEAR;
            cnt_ff     <= `CH_CYC_CLEAR;
            clr_ff     <= `CH_PTR_ZERO;
            ptr_ff     <= `CH_PTR_ZERO;
            gsel_ff    <= `CH_SEL_DISPLAY_RAM;
            shift_ff   <= `CH_PTR_ZERO;
            mode_ff    <= `CH_MODE_RST;
            busy_ff    <= 1'b1;
            pwr_ff     <= 1'b1;
            rdv_ff     <= 1'b0;
            rd_data_ff <= `CH_OP_NOP;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            clr_ff     <= nxt_clr;
            ptr_ff     <= nxt_ptr;
            gsel_ff    <= nxt_gsel;
            shift_ff   <= nxt_shift;
            mode_ff    <= nxt_mode;
            busy_ff    <= nxt_state != ST_IDLE;
            pwr_ff     <= ~nxt_mode.disp_on;
            rdv_ff     <= nxt_rdv;
            rd_data_ff <= nxt_rdata;
        end
    end

    // (R4) holding registers load only on acceptance
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ihr_ff  <= `CH_OP_NOP;
            dhr_ff  <= `CH_OP_NOP;
            data_ff <= 1'b0;
        end else if (acc_cmd || acc_dwr) begin
            ihr_ff  <= acc_cmd ? req_data : ihr_ff;
            dhr_ff  <= acc_dwr ? req_data : dhr_ff;
            data_ff <= acc_dwr;
        end
    end

    // Outputs straight from flops
    assign BUSY        = busy_ff;
    assign RD_VALID    = rdv_ff;
    assign RD_DATA     = rd_data_ff;
    assign MODE        = mode_ff;
    assign RAM_POINTER = ptr_ff;
    assign DISP_SHIFT  = shift_ff;
    assign PWR_DOWN    = pwr_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_busy_holds: assert property (acc_cmd |=> busy_ff [*3]) // (R6)
        else $error("busy dropped during command");
    a_nop_cost: assert property ( // (R10)
        acc_cmd && req_data == `CH_OP_NOP |=> busy_ff [*3] ##1 !busy_ff)
        else $error("nop cost wrong");
    a_clear_cost: assert property ( // (R13)
        do_clear |-> ##164 busy_ff ##1 !busy_ff)
        else $error("clear cost wrong");
    a_busy_drop: assert property ( // (R5)
        !idle && req_wr |=> $stable(ihr_ff) && $stable(dhr_ff))
        else $error("busy write not dropped");
    a_status_read: assert property ( // (R11)
        bf_read && !(st_read && last) |=>
            RD_VALID && RD_DATA == {$past(busy_ff), $past(ptr_ff)})
        else $error("status read wrong");
    a_write_step: assert property (do_dwr |=> ptr_ff == $past(step_ptr)) // (R21)
        else $error("pointer not stepped");
    a_write_shift: assert property ( // (R22)
        do_dwr && mode_ff.shift_en |=> shift_ff == $past(step_shft))
        else $error("display not shifted");
    a_clear_end: assert property ( // (R23)
        st_clear && last |=> ptr_ff == `CH_PTR_ZERO && mode_ff.incr)
        else $error("clear end state wrong");
    a_glyph_keep: assert property ( // (R18)
        do_cmd && !ext && top_is(c, `CH_OP_CG) |=>
            gsel_ff && ptr_ff[`CH_PTR_MSB] == $past(ptr_ff[`CH_PTR_MSB]))
        else $error("glyph pointer wrong");
    a_ext_reserved: assert property ( // (R26)
        do_cmd && ext && c[7:`CH_EXT_RSV_LSB] != 4'h0 && !top_is(c, `CH_OP_FUNC) |=>
            $stable(mode_ff) && $stable(ptr_ff))
        else $error("reserved code acted");

endmodule

// ### rtl/ch_defines.svh
/*
 Constants of the character display instruction decoder: cycle costs,
 opcode top-bit positions, field positions and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CH_DEFINES_SVH
`define CH_DEFINES_SVH

// ==========================================================
// Execution costs in oscillator cycles
`define CH_CYC_CMD     8'd3
`define CH_CYC_CLEAR   8'd165
`define CH_CYC_ONE     8'd1

// ==========================================================
// Opcode classes, named by the highest set bit
`define CH_OP_CLEAR    0
`define CH_OP_HOME     1
`define CH_OP_ENTRY    2
`define CH_OP_DISP     3
`define CH_OP_SHIFT    4
`define CH_OP_FUNC     5
`define CH_OP_CG       6
`define CH_OP_DD       7
`define CH_OP_NOP      8'h00

// ==========================================================
// Field positions inside command and control bytes
`define CH_B_DL        4
`define CH_B_M         2
`define CH_B_H         0
`define CH_B_ID        1
`define CH_B_S         0
`define CH_B_D         2
`define CH_B_C         1
`define CH_B_B         0
`define CH_B_SC        3
`define CH_B_RL        2
`define CH_B_L         0
`define CH_B_P         1
`define CH_B_Q         0
`define CH_B_IM        2
`define CH_B_IB        1
`define CH_B_CO        7
`define CH_B_RS        6
`define CH_CG_MSB      5
`define CH_PTR_MSB     6
`define CH_EXT_RSV_LSB 4

// ==========================================================
// Values
`define CH_CTRL_ZERO   6'h00
`define CH_BLANK_CHAR  8'h20
`define CH_DISPLAY_RAM_SIZE  7'h50
`define CH_PTR_ONE     7'h01
`define CH_PTR_ZERO    7'h00
`define CH_SEL_DISPLAY_RAM   1'b0
`define CH_SEL_GLYPH_RAM   1'b1
`define CH_MODE_RST    13'h1200

`endif

// ### rtl/ch_pkg.sv
/*
 Types of the character display instruction decoder.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ch_pkg;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_READ,
        ST_CLEAR
    } ch_state_t;

    // ==========================================================
    // Parallel host strobe group
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       register_select;
        logic [7:0] data;
    } ch_host_req_t;

    // Byte stream from the two-wire bus front end
    typedef struct packed {
        logic       start;
        logic       byte_vld;
        logic       rd_req;
        logic [7:0] data;
    } ch_i2c_in_t;

    // Mode bits, first field is the top bit
    typedef struct packed {
        logic bus_width_sel;
        logic two_line;
        logic ext_set;
        logic incr;
        logic shift_en;
        logic disp_on;
        logic cursor_on;
        logic blink_on;
        logic mirror;
        logic col_rev;
        logic row_rev;
        logic icon_mode;
        logic icon_blink;
    } ch_mode_t;

endpackage

// ### rtl/ch_ram.sv
/*
 Single-port byte memory holding display RAM and glyph RAM.
 Assumes one access per cycle; read data come from a register.
*/
`timescale 1ns/1ps

module ch_ram (
    input  wire logic       clk,
    input  wire logic       we,
    input  wire logic       re,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata_ff
);

    logic [7:0] mem [0:255];

    // ==========================================================
    // Storage; no reset, display bytes 0x00 to 0x4F are defined by the clear walk
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // Read port holds its word until the next read
    always_ff @(posedge clk) begin
        if (re) begin
            rdata_ff <= mem[addr];
        end
    end

endmodule

// ### sim/ch_host_bfm.sv
/*
 Host model: parallel strobes and the two-wire byte stream.
 Assumes calls start 1 ns after a rising clk edge.
*/
`timescale 1ns/1ps
module ch_host_bfm
    import ch_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    busy,
    input  wire logic    rd_valid,
    output ch_host_req_t req,
    output ch_i2c_in_t   i2c
);
    // Lines quiet until the first request
    initial begin
        req = '0;
        i2c = '0;
    end
    // ==============================
    // Waits
    // poll busy low, or wait for an answer
    task automatic wt(input logic a, output int n);
        n = 0;
        while ((a ? !rd_valid : busy) && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 400) ch_decoder_tb_top.complete_run(1);
    endtask
    // One-cycle strobe; data inverted once released so nothing stale lingers
    task automatic hp(input logic w, s, input logic [7:0] v);
        int n;
        // Let an edge pass so the release and the next request never share a time step
        @(posedge clk);
        #1;
        req = '{w, !w, s, v};
        @(posedge clk);
        #1;
        req = '{1'b0, 1'b0, s, ~v};
        if (!w) wt(1'b1, n);
    endtask
    // elements {start, read, byte}, one pulse each
    task automatic seq(input logic [9:0] b[$]);
        int n;
        foreach (b[i]) begin
            @(posedge clk);
            #1;
            i2c = '{b[i][9], b[i][9:8] == 2'b00, b[i][8], b[i][7:0]};
            @(posedge clk);
            #1;
            i2c = '{1'b0, 1'b0, 1'b0, ~b[i][7:0]};
            wt(b[i][8], n);
        end
    endtask
endmodule

// ### sim/ch_decoder_tb_top.sv
/*
 Bench of the instruction decoder, driven through the host model.
 Assumes the package, the design and the host model compile first.
*/
`timescale 1ns/1ps
module ch_decoder_tb_top;
    import ch_pkg::*;
    logic         clk, rst_n, busy, rd_valid, pwr_down;
    logic [7:0]   rd_data;
    logic [6:0]   ptr, shift;
    ch_host_req_t rq;
    ch_i2c_in_t   ii;
    ch_mode_t     mode;
    int           n_errors = 0, n_tests = 0, n;
    // ==============================
    // Design and host
    ch_decoder dut_u (.CLK(clk), .RST_N(rst_n), .HOST_REQ(rq), .I2C_IN(ii), .BUSY(busy),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .MODE(mode), .RAM_POINTER(ptr),
        .DISP_SHIFT(shift), .PWR_DOWN(pwr_down));
    ch_host_bfm host_u (.clk(clk), .busy(busy), .rd_valid(rd_valid), .req(rq), .i2c(ii));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // One counted compare
    task automatic cmp(input logic [15:0] g, e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Access {sel, byte}; judge cost 3, {pointer, shift} and mode
    task automatic cmd(input logic [8:0] v, input logic [13:0] ps, input logic [12:0] m);
        host_u.hp(1'b1, v[8], v[7:0]);
        host_u.wt(1'b0, n);
        cmp(16'(n), 16'h3);
        cmp(16'({ptr, shift}), 16'(ps));
        cmp(16'(mode), 16'(m));
    endtask
    // Verdict; a host wait that ran out arrives with x set
    task automatic complete_run(input int x);
        n_errors += x;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Reset state; status read and dropped command during the clear
    task automatic t_boot();
        cmp(16'({busy, pwr_down, mode}), 16'h7200);
        rst_n = 1'b1;
        host_u.hp(1'b0, 1'b0, 8'h00);
        cmp(16'(rd_data), 16'h80);
        host_u.hp(1'b1, 1'b0, 8'h0f);
        host_u.wt(1'b0, n);
        cmp(16'(n), 16'd161);
        cmp(16'({pwr_down, mode}), 16'h3200);
    endtask
    // Display on, pointer loads, write, read back, decrement
    task automatic t_ram();
        cmd(9'h00f, 14'h0, 13'h12e0);
        cmp(16'(pwr_down), 16'h0);
        cmd(9'h000, 14'h0, 13'h12e0);
        cmd(9'h085, 14'h280, 13'h12e0);
        cmd(9'h141, 14'h300, 13'h12e0);
        cmd(9'h085, 14'h280, 13'h12e0);
        host_u.hp(1'b0, 1'b1, 8'h00);
        cmp(16'(rd_data), 16'h41);
        cmd(9'h004, 14'h300, 13'h10e0);
        cmd(9'h142, 14'h280, 13'h10e0);
        cmd(9'h0c5, 14'h2280, 13'h10e0);
        cmd(9'h041, 14'h2080, 13'h10e0);
    endtask
    // Shift on writes, cursor and display moves, home, clear
    task automatic t_shift();
        cmd(9'h007, 14'h2080, 13'h13e0);
        cmd(9'h080, 14'h0, 13'h13e0);
        cmd(9'h143, 14'h81, 13'h13e0);
        cmd(9'h014, 14'h101, 13'h13e0);
        cmd(9'h018, 14'h102, 13'h13e0);
        cmd(9'h002, 14'h0, 13'h13e0);
        cmd(9'h005, 14'h0, 13'h11e0);
        host_u.hp(1'b1, 1'b0, 8'h01);
        host_u.wt(1'b0, n);
        cmp(16'(n), 16'd165);
        cmp(16'({ptr, mode}), 16'h13e0);
        host_u.hp(1'b0, 1'b1, 8'h00);
        cmp(16'(rd_data), 16'h20);
    endtask
    // Extended fields, reserved codes, back to basic
    // a real host never sends 0x01, 0x10 or 0x80 here; they only probe
    task automatic t_ext();
        cmd(9'h035, 14'h81, 13'h1fe0);
        cmd(9'h003, 14'h81, 13'h1ff0);
        cmd(9'h007, 14'h81, 13'h1ffc);
        cmd(9'h00e, 14'h81, 13'h1fff);
        cmd(9'h001, 14'h81, 13'h1fff);
        cmd(9'h010, 14'h81, 13'h1fff);
        cmd(9'h080, 14'h81, 13'h1fff);
        cmd(9'h030, 14'h81, 13'h13ff);
    endtask
    // Two-wire: control, command, data pair; bad control byte; status read
    task automatic t_i2c();
        host_u.seq({10'h200, 10'h080, 10'h082, 10'h040, 10'h061, 10'h062});
        cmp(16'(ptr), 16'h4);
        host_u.seq({10'h200, 10'h0c1, 10'h000, 10'h080, 10'h100});
        cmp(16'(rd_data), 16'h00);
    endtask
    // Reset for 5 cycles, then the scenarios
    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        t_boot();
        t_ram();
        t_shift();
        t_ext();
        t_i2c();
        complete_run(0);
    end
endmodule
